/* File: hdl/backplane_protection_switch.v */
// receive-side protection switching and channel powerdown for eight backplane channels
// assumes all inputs are synchronous to ref_clk; recovered clocks arrive as one-cycle ticks
`timescale 1ns/1ps
`include "prot_switch_defines.vh"

// Overview of operation
// - disabled channel powered down with its serial macro
// - all channels powered down after reset
// - per-channel parallel and overhead output enables
// - parallel switching only with alignment FIFO used
// - pointer stage bypass leaves parallel switching working
// - select one picks main, zero picks protect
// - pin control switches parallel data only
// - software control switches data and overhead
// - input select zero work, one protect
// - work default; no status for unselected input
// - software enable and per-channel input select bits
// - bypass follows recovered clock, else reference clock
// - control writes only with lock key present
module backplane_protection_switch
#(
	parameter CH = 8,
	parameter PAIRS = 4,
	parameter FIFO_DEPTH = `PAIR_FIFO_DEPTH,
	parameter FIFO_AW = `PAIR_FIFO_AW
)
(
	input wire ref_clk, // reference clock
	input wire rst, // async reset, active high
	input wire reg_wr, // register write strobe
	input wire reg_rd, // register read strobe
	input wire [`REG_ADDR_W-1:0] reg_addr, // absolute register address
	input wire [`REG_DATA_W-1:0] reg_wdata, // write data
	output reg [`REG_DATA_W-1:0] reg_rdata, // read data
	output reg reg_ack, // access done pulse
	input wire align_fifo_bypass, // alignment FIFO bypassed
	input wire pointer_bypass, // pointer stage bypassed
	input wire [CH-1:0] recovered_clk_tick, // per-channel recovered clock tick
	input wire pair_select_a_first, // pair 0 main select
	input wire pair_select_a_second, // pair 1 main select
	input wire pair_select_b_first, // pair 2 main select
	input wire pair_select_b_second, // pair 3 main select
	input wire input_pair_select_ch0, // ch0 protect input select
	input wire input_pair_select_ch1, // ch1 protect input select
	input wire input_pair_select_ch2, // ch2 protect input select
	input wire input_pair_select_ch3, // ch3 protect input select
	input wire input_pair_select_ch4, // ch4 protect input select
	input wire input_pair_select_ch5, // ch5 protect input select
	input wire input_pair_select_ch6, // ch6 protect input select
	input wire input_pair_select_ch7, // ch7 protect input select
	input wire [CH-1:0] work_serial_input, // work serial bits
	input wire [CH-1:0] protect_serial_input, // protect serial bits
	output reg [CH-1:0] cdr_serial_in, // bit fed to recovery
	output reg [CH-1:0] input_select_protect, // protect input in use
	input wire [CH-1:0] framer_status, // framer stream status
	output reg [CH-1:0] work_status, // status of work input
	output reg [CH-1:0] protect_status, // status of protect input
	input wire [CH*8-1:0] ch_data, // aligned bytes per channel
	input wire [CH-1:0] ch_valid, // byte present
	output wire [CH-1:0] ch_ready, // byte taken
	input wire [CH-1:0] serial_overhead_in, // overhead bit per channel
	output reg [CH-1:0] serial_overhead_out, // overhead bit to fabric
	output wire [PAIRS*8-1:0] parallel_out, // pair bytes, pair0 low
	output wire [PAIRS-1:0] parallel_out_valid, // pair byte present
	input wire [PAIRS-1:0] parallel_out_ready, // fabric takes pair byte
	output wire [CH-1:0] parallel_oe, // parallel bus enable
	output wire [CH-1:0] overhead_oe, // overhead output enable
	output wire [CH-1:0] macro_powerdown // serial macro powered down
);
	reg [7:0] scratch_reg; // free scratch byte
	reg [7:0] lock_msb_reg; // lock key high byte
	reg [7:0] lock_lsb_reg; // lock key low byte
	reg [7:0] chan_enable_reg; // channel enables
	reg [7:0] diff_input_switch_ctrl_reg; // input switch software enable
	reg [7:0] parallel_switch_ctrl_reg; // parallel switch control
	reg [7:0] diff_input_select_reg; // input selects from software
	reg denied_reg; // write refused while locked
	reg [7:0] rdata_next; // read mux
	wire unlocked; // key present
	wire locked_addr; // address in protected window
	wire wr_ok; // write allowed
	wire denied_set; // refused write event
	wire denied_clr; // software clears refusal flag
	wire [CH-1:0] diff_pin_sel; // input selects from pins
	wire [PAIRS-1:0] par_pin_sel; // pair selects from pins
	wire [CH-1:0] diff_sel; // input select in force
	wire [PAIRS-1:0] par_sel; // pair select in force
	wire par_sw_en; // software owns pair selects
	wire switch_active; // parallel switching possible
	wire [CH-1:0] enabled; // channel out of powerdown

	assign unlocked = (lock_msb_reg == `LOCK_KEY_MSB) && (lock_lsb_reg == `LOCK_KEY_LSB);
	assign locked_addr = (reg_addr >= `ADDR_LOCKED_FIRST) && (reg_addr <= `ADDR_LOCKED_LAST);
	assign wr_ok = reg_wr && (unlocked || !locked_addr);
	assign denied_set = reg_wr && locked_addr && !unlocked;
	assign denied_clr = wr_ok && (reg_addr == `ADDR_SWITCH_STATUS) && reg_wdata[`STAT_DENIED_BIT];
	assign enabled = chan_enable_reg[CH-1:0];
	assign macro_powerdown = ~enabled;
	assign parallel_oe = enabled;
	assign overhead_oe = enabled;
	assign diff_pin_sel = {input_pair_select_ch7, input_pair_select_ch6, input_pair_select_ch5,
		input_pair_select_ch4, input_pair_select_ch3, input_pair_select_ch2, input_pair_select_ch1,
		input_pair_select_ch0};
	assign par_pin_sel = {pair_select_b_second, pair_select_b_first, pair_select_a_second,
		pair_select_a_first};
	assign par_sw_en = parallel_switch_ctrl_reg[`PAR_SW_EN_BIT];
	// pointer stage bypass does not enter the switching condition
	assign switch_active = !align_fifo_bypass;

	// register writes; lock bytes and scratch are never protected
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			scratch_reg <= `RST_SCRATCH;
			lock_msb_reg <= `RST_LOCK;
			lock_lsb_reg <= `RST_LOCK;
			chan_enable_reg <= `RST_CHAN_ENABLE;
			diff_input_switch_ctrl_reg <= `RST_DIFF_CTRL;
			parallel_switch_ctrl_reg <= `RST_PAR_CTRL;
			diff_input_select_reg <= `RST_DIFF_SELECT;
		end
		else if (wr_ok)
		begin
			case (reg_addr)
				`ADDR_SCRATCH: scratch_reg <= reg_wdata;
				`ADDR_LOCK_MSB: lock_msb_reg <= reg_wdata;
				`ADDR_LOCK_LSB: lock_lsb_reg <= reg_wdata;
				`ADDR_CHAN_ENABLE: chan_enable_reg <= reg_wdata;
				`ADDR_DIFF_INPUT_SWITCH_CTRL: diff_input_switch_ctrl_reg <= reg_wdata;
				`ADDR_PARALLEL_SWITCH_CTRL: parallel_switch_ctrl_reg <= reg_wdata;
				`ADDR_DIFF_INPUT_SELECT: diff_input_select_reg <= reg_wdata;
				default: scratch_reg <= scratch_reg; // unmapped, nothing stored
			endcase
		end
	end

	// refused-write flag; a new refusal beats a clear
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			denied_reg <= 1'b0;
		else if (denied_set)
			denied_reg <= 1'b1;
		else if (denied_clr)
			denied_reg <= 1'b0;
	end

	// read mux, unused bits and addresses read zero
	always @*
	begin
		rdata_next = 8'h00;
		case (reg_addr)
			`ADDR_SCRATCH: rdata_next = scratch_reg;
			`ADDR_LOCK_MSB: rdata_next = lock_msb_reg;
			`ADDR_LOCK_LSB: rdata_next = lock_lsb_reg;
			`ADDR_CHAN_ENABLE: rdata_next = chan_enable_reg;
			`ADDR_SWITCH_STATUS:
			begin
				rdata_next[`STAT_DENIED_BIT] = denied_reg;
				rdata_next[`STAT_UNLOCKED_BIT] = unlocked;
				rdata_next[`STAT_ALIGN_BIT] = switch_active;
			end
			`ADDR_DIFF_INPUT_SWITCH_CTRL: rdata_next = diff_input_switch_ctrl_reg & 8'h01;
			`ADDR_PARALLEL_SWITCH_CTRL: rdata_next = parallel_switch_ctrl_reg & 8'h1f;
			`ADDR_DIFF_INPUT_SELECT: rdata_next = diff_input_select_reg;
			default: rdata_next = 8'h00; // unmapped reads zero
		endcase
	end

	// read data and acknowledge, one cycle after the strobe
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			reg_rdata <= 8'h00;
			reg_ack <= 1'b0;
		end
		else
		begin
			reg_ack <= reg_wr || reg_rd;
			if (reg_rd)
				reg_rdata <= rdata_next;
		end
	end

	// differential input select owner
	select_source #(.N(CH), .RESET_SEL({CH{1'b0}})) u_diff_sel
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.sw_en(diff_input_switch_ctrl_reg[`DIFF_SW_EN_BIT]),
		.pin_sel(diff_pin_sel),
		.reg_sel(diff_input_select_reg[CH-1:0]),
		.eff_sel(diff_sel)
	);

	// parallel pair select owner
	select_source #(.N(PAIRS), .RESET_SEL({PAIRS{1'b1}})) u_par_sel
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.sw_en(par_sw_en),
		.pin_sel(par_pin_sel),
		.reg_sel(parallel_switch_ctrl_reg[PAIRS-1:0]),
		.eff_sel(par_sel)
	);

	// input buffer mux ahead of recovery and status gating
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			cdr_serial_in <= {CH{1'b0}};
			input_select_protect <= {CH{1'b0}};
			work_status <= {CH{1'b0}};
			protect_status <= {CH{1'b0}};
		end
		else
		begin
			input_select_protect <= diff_sel;
			cdr_serial_in <= enabled & ((diff_sel & protect_serial_input) |
				(~diff_sel & work_serial_input));
			work_status <= enabled & ~diff_sel & framer_status;
			protect_status <= enabled & diff_sel & framer_status;
		end
	end

	genvar p;
	generate
		for (p = 0; p < PAIRS; p = p + 1)
		begin : g_pair
			localparam [31:0] FIRST_IDX = 2 * p; // even channel of the pair
			wire use_second; // protect channel chosen
			wire [2:0] src_idx; // channel feeding the pair
			wire src_tick; // source timing strobe
			wire push_valid; // byte offered to buffer
			wire fifo_in_ready; // buffer has room
			wire [7:0] src_byte; // selected byte
			wire ovh_first; // overhead for first channel output
			assign use_second = switch_active && !par_sel[p];
			// odd channel is the even one plus the protect choice
			assign src_idx = {FIRST_IDX[2:1], use_second};
			// bypass runs on the recovered clock of the source, else every reference cycle
			assign src_tick = align_fifo_bypass ? recovered_clk_tick[src_idx] : 1'b1;
			assign src_byte = ch_data[src_idx*8 +: 8];
			assign push_valid = ch_valid[src_idx] && enabled[src_idx] && src_tick;
			// both channels drain while the buffer has room, in bypass the chosen one only on its tick; the unchosen stream is dropped
			assign ch_ready[2*p] = fifo_in_ready && (src_tick || use_second);
			assign ch_ready[2*p+1] = fifo_in_ready && (src_tick || !use_second);
			// software control moves overhead with the data, pin control does not
			assign ovh_first = (use_second && par_sw_en) ? serial_overhead_in[2*p+1] :
				serial_overhead_in[2*p];

			stream_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .ADDR_W(FIFO_AW)) u_fifo
			(
				.ref_clk(ref_clk),
				.rst(rst),
				.in_valid(push_valid),
				.in_ready(fifo_in_ready),
				.in_data(src_byte),
				.out_valid(parallel_out_valid[p]),
				.out_ready(parallel_out_ready[p]),
				.out_data(parallel_out[p*8 +: 8])
			);

			// overhead bits, silent while powered down; clocked on the reference clock ref_clk
			always @(posedge ref_clk or posedge rst)
			begin
				if (rst)
				begin
					serial_overhead_out[2*p] <= 1'b0;
					serial_overhead_out[2*p+1] <= 1'b0;
				end
				else
				begin
					serial_overhead_out[2*p] <= ovh_first & enabled[2*p];
					serial_overhead_out[2*p+1] <= serial_overhead_in[2*p+1] & enabled[2*p+1];
				end
			end
		end
	endgenerate
endmodule

/* File: hdl/prot_switch_defines.vh */
// register addresses, field positions and reset values of the protection switch block
// assumes an 8-bit register port with absolute 18-bit addresses
`ifndef PROT_SWITCH_DEFINES_VH
`define PROT_SWITCH_DEFINES_VH

// register port widths
`define REG_ADDR_W 18
`define REG_DATA_W 8

// register addresses
`define ADDR_SCRATCH 18'h30003
`define ADDR_LOCK_MSB 18'h30004
`define ADDR_LOCK_LSB 18'h30005
`define ADDR_CHAN_ENABLE 18'h30006
`define ADDR_SWITCH_STATUS 18'h30007
`define ADDR_DIFF_INPUT_SWITCH_CTRL 18'h30008
`define ADDR_PARALLEL_SWITCH_CTRL 18'h30009
`define ADDR_DIFF_INPUT_SELECT 18'h3000a

// write-protected window
`define ADDR_LOCKED_FIRST 18'h30006
`define ADDR_LOCKED_LAST 18'h300ff

// lock key bytes
`define LOCK_KEY_MSB 8'h05
`define LOCK_KEY_LSB 8'h80

// field positions
`define DIFF_SW_EN_BIT 0
`define PAR_SW_EN_BIT 4
`define STAT_DENIED_BIT 0
`define STAT_UNLOCKED_BIT 1
`define STAT_ALIGN_BIT 2

// reset values
`define RST_SCRATCH 8'h00
`define RST_LOCK 8'h00
`define RST_CHAN_ENABLE 8'h00
`define RST_DIFF_CTRL 8'h00
`define RST_PAR_CTRL 8'h0f
`define RST_DIFF_SELECT 8'h00

// buffering
`define PAIR_FIFO_DEPTH 16
`define PAIR_FIFO_AW 4

`endif

/* File: hdl/select_source.v */
// registered choice between pin selects and register selects
// assumes pin selects are synchronous to ref_clk
`timescale 1ns/1ps
module select_source
#(
	parameter N = 8,
	parameter [N-1:0] RESET_SEL = {N{1'b0}}
)
(
	input wire ref_clk, // core clock
	input wire rst, // async reset, active high
	input wire sw_en, // software owns the selects
	input wire [N-1:0] pin_sel, // selects from fabric pins
	input wire [N-1:0] reg_sel, // selects from register
	output reg [N-1:0] eff_sel // select in force
);
	reg [N-1:0] eff_next; // next select

	// pick the owner of the selects
	always @*
	begin
		if (sw_en)
			eff_next = reg_sel;
		else
			eff_next = pin_sel;
	end

	// hold the select in force
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			eff_sel <= RESET_SEL;
		else
			eff_sel <= eff_next;
	end
endmodule

/* File: hdl/stream_fifo.v */
// flip-flop FIFO with valid/ready on both sides
// assumes DEPTH is a power of two and ADDR_W is log2 of DEPTH
`timescale 1ns/1ps
module stream_fifo
#(
	parameter WIDTH = 9,
	parameter DEPTH = 16,
	parameter ADDR_W = 4
)
(
	input wire ref_clk, // core clock
	input wire rst, // async reset, active high
	input wire in_valid, // write side offers a word
	output wire in_ready, // room for a word
	input wire [WIDTH-1:0] in_data, // word to store
	output wire out_valid, // a word is waiting
	input wire out_ready, // read side takes the word
	output wire [WIDTH-1:0] out_data // oldest word
);
	localparam [ADDR_W:0] FULL_COUNT = DEPTH; // occupancy when full

	reg [WIDTH-1:0] mem_reg [0:DEPTH-1]; // storage flops
	reg [ADDR_W-1:0] wr_ptr_reg; // next write slot
	reg [ADDR_W-1:0] rd_ptr_reg; // next read slot
	reg [ADDR_W:0] count_reg; // words held
	wire push; // word accepted
	wire pop; // word handed out

	assign in_ready = (count_reg != FULL_COUNT);
	assign out_valid = (count_reg != {(ADDR_W+1){1'b0}});
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_reg[rd_ptr_reg];

	// storage write, no reset needed on data
	always @(posedge ref_clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	// pointers and occupancy
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_reg <= {ADDR_W{1'b0}};
			rd_ptr_reg <= {ADDR_W{1'b0}};
			count_reg <= {(ADDR_W+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule

/* File: test/backplane_protection_switch_tb.sv */
// self-checking bench for the protection switch
// assumes the fabric model drives the select pins and sinks pair bytes
`timescale 1ns/1ps
`include "prot_switch_defines.vh"
module backplane_protection_switch_tb;
	reg ref_clk = 1'b0;
	reg rst = 1'b1;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg [17:0] reg_addr = 18'h0;
	reg [7:0] reg_wdata = 8'h0;
	reg bypass = 1'b0;
	reg ptr_bypass = 1'b0;
	reg stall = 1'b0;
	reg [7:0] tick = 8'h0, want_input = 8'h0, work_in = 8'h00, prot_in = 8'hff, framer = 8'hff;
	reg [7:0] oh_in = 8'h0, ch_valid = 8'h0, rv;
	reg [3:0] want_pair = 4'hf;
	reg [63:0] ch_data = 64'h4746454443424140; // channel n sends 8'h40+n
	reg [15:0] c0;
	wire [3:0] pair_sel, pov, prdy;
	wire [7:0] input_sel, cdr, isp, wst, pst, ch_ready, oh_out, poe, ooe, pdn, reg_rdata;
	wire [31:0] pout, got;
	wire [15:0] got_cnt;
	wire reg_ack;
	integer err_total = 0, num_checks = 0, i, n;
	always #4 ref_clk = ~ref_clk;
	backplane_protection_switch i_dut (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.align_fifo_bypass(bypass), .pointer_bypass(ptr_bypass), .recovered_clk_tick(tick),
		.pair_select_a_first(pair_sel[0]), .pair_select_a_second(pair_sel[1]),
		.pair_select_b_first(pair_sel[2]), .pair_select_b_second(pair_sel[3]),
		.input_pair_select_ch0(input_sel[0]), .input_pair_select_ch1(input_sel[1]),
		.input_pair_select_ch2(input_sel[2]), .input_pair_select_ch3(input_sel[3]),
		.input_pair_select_ch4(input_sel[4]), .input_pair_select_ch5(input_sel[5]),
		.input_pair_select_ch6(input_sel[6]), .input_pair_select_ch7(input_sel[7]),
		.work_serial_input(work_in), .protect_serial_input(prot_in), .cdr_serial_in(cdr),
		.input_select_protect(isp), .framer_status(framer), .work_status(wst), .protect_status(pst),
		.ch_data(ch_data), .ch_valid(ch_valid), .ch_ready(ch_ready), .serial_overhead_in(oh_in),
		.serial_overhead_out(oh_out), .parallel_out(pout), .parallel_out_valid(pov), .parallel_out_ready(prdy),
		.parallel_oe(poe), .overhead_oe(ooe), .macro_powerdown(pdn));
	fabric_model i_fab (.ref_clk(ref_clk), .rst(rst), .want_pair(want_pair), .want_input(want_input),
		.stall(stall), .pair_sel(pair_sel), .input_sel(input_sel), .pair_data(pout), .pair_valid(pov),
		.pair_ready(prdy), .got(got), .got_cnt(got_cnt));
	// counts, verdict and end of run
	task give_verdict;
	begin
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	task chk(input string nm, input [63:0] seen, input [63:0] exp);
	begin
		num_checks = num_checks + 1;
		if (seen !== exp)
		begin
			err_total = err_total + 1;
			$display("Error %s expected %0h seen %0h", nm, exp, seen);
		end
	end
	endtask
	task cyc(input integer k);
	begin
		repeat (k) @(posedge ref_clk);
		#1;
	end
	endtask
	// one register access, bounded wait for the acknowledge
	task acc(input integer w, input [17:0] a, input [7:0] d);
	begin
		@(posedge ref_clk);
		reg_wr <= (w != 0);
		reg_rd <= (w == 0);
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		n = 0;
		#1;
		while (reg_ack !== 1'b1 && n < 4)
		begin
			cyc(1);
			n = n + 1;
		end
		if (n == 4)
		begin
			err_total = err_total + 1;
			give_verdict;
		end
		rv = reg_rdata;
	end
	endtask
	task push(input [7:0] v);
	begin
		@(posedge ref_clk);
		ch_valid <= v;
		@(posedge ref_clk);
		ch_valid <= 8'h00;
	end
	endtask
	task t_reset;
	begin
		cyc(1);
		chk("powerdown", pdn, 8'hff);
		acc(0, `ADDR_CHAN_ENABLE, 8'h0);
		chk("enable reg", rv, `RST_CHAN_ENABLE);
		acc(0, `ADDR_DIFF_INPUT_SWITCH_CTRL, 8'h0);
		chk("input ctrl", rv, `RST_DIFF_CTRL);
		acc(0, `ADDR_PARALLEL_SWITCH_CTRL, 8'h0);
		chk("pair ctrl", rv, `RST_PAR_CTRL);
		$display("reset test done");
	end
	endtask
	task t_lock;
	begin
		acc(1, `ADDR_CHAN_ENABLE, 8'hff);
		acc(0, `ADDR_CHAN_ENABLE, 8'h0);
		chk("locked write", rv, 8'h00);
		acc(0, `ADDR_SWITCH_STATUS, 8'h0);
		chk("denied flag", rv[`STAT_DENIED_BIT], 1'b1);
		acc(1, `ADDR_LOCK_MSB, `LOCK_KEY_MSB);
		acc(1, `ADDR_LOCK_LSB, `LOCK_KEY_LSB);
		acc(1, `ADDR_CHAN_ENABLE, 8'hff);
		chk("bus enable", poe, 8'hff);
		chk("powerdown", pdn, 8'h00);
		acc(0, 18'h300ff, 8'h0);
		chk("unmapped", rv, 8'h00);
		$display("lock test done");
	end
	endtask
	task t_input;
	begin
		for (i = 0; i < 2; i = i + 1)
		begin
			@(posedge ref_clk) want_input <= i ? 8'ha5 : 8'h5a;
			cyc(4);
			chk("input sel", isp, i ? 8'ha5 : 8'h5a);
			chk("recovery bits", cdr, i ? 8'ha5 : 8'h5a);
			chk("protect status", pst, i ? 8'ha5 : 8'h5a);
			chk("work status", wst, i ? 8'h5a : 8'ha5);
		end
		acc(1, `ADDR_DIFF_INPUT_SELECT, 8'hc3);
		acc(1, `ADDR_DIFF_INPUT_SWITCH_CTRL, 8'h01);
		cyc(3);
		chk("software input sel", isp, 8'hc3);
		acc(1, `ADDR_DIFF_INPUT_SWITCH_CTRL, 8'h00);
		$display("input test done");
	end
	endtask
	task t_pair;
	begin
		@(posedge ref_clk) ptr_bypass <= 1'b1;
		for (i = 0; i < 2; i = i + 1)
		begin
			@(posedge ref_clk) want_pair <= i ? 4'hf : 4'h0;
			oh_in <= 8'haa;
			cyc(4);
			push(8'hff);
			cyc(4);
			chk("pair bytes", got, i ? 32'h46444240 : 32'h47454341);
			chk("overhead", oh_out, 8'haa);
		end
		acc(1, `ADDR_PARALLEL_SWITCH_CTRL, 8'h10);
		cyc(2);
		push(8'hff);
		cyc(4);
		chk("software pair bytes", got, 32'h47454341);
		chk("software overhead", oh_out, 8'hff);
		acc(1, `ADDR_PARALLEL_SWITCH_CTRL, 8'h0f);
		$display("pair test done");
	end
	endtask
	task t_fill;
	begin
		@(posedge ref_clk) stall <= 1'b1;
		c0 = got_cnt;
		ch_valid <= 8'h01;
		n = 0;
		repeat (20)
		begin
			@(negedge ref_clk);
			if (ch_ready[0] === 1'b1)
				n = n + 1;
		end
		@(posedge ref_clk) ch_valid <= 8'h00;
		chk("accepted", n, 16);
		@(posedge ref_clk) stall <= 1'b0;
		cyc(24);
		chk("drained", got_cnt - c0, 16'd16);
		$display("fill test done");
	end
	endtask
	task t_bypass;
	begin
		@(posedge ref_clk) bypass <= 1'b1;
		want_pair <= 4'h0;
		c0 = got_cnt;
		ch_valid <= 8'h01;
		cyc(4);
		chk("no tick", got_cnt - c0, 16'd0);
		@(posedge ref_clk) tick <= 8'h01;
		@(posedge ref_clk) tick <= 8'h00;
		ch_valid <= 8'h00;
		cyc(3);
		chk("one tick", got_cnt - c0, 16'd1);
		@(posedge ref_clk) bypass <= 1'b0;
		want_pair <= 4'hf;
		$display("bypass test done");
	end
	endtask
	task t_down;
	begin
		acc(1, `ADDR_CHAN_ENABLE, 8'hfe);
		chk("powerdown", pdn, 8'h01);
		chk("overhead enable", ooe, 8'hfe);
		c0 = got_cnt;
		push(8'h01);
		cyc(4);
		chk("disabled data", got_cnt - c0, 16'd0);
		chk("disabled recovery", cdr[0], 1'b0);
		$display("powerdown test done");
	end
	endtask
	// reset, then every scenario in turn
	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset;
		t_lock;
		t_input;
		t_pair;
		t_fill;
		t_bypass;
		t_down;
		give_verdict;
	end
endmodule

/* File: test/bps_sva.sv */
// port assertions for the protection switch
// assumes one reference clock and an async active-high reset
`timescale 1ns/1ps
module bps_checker
#(
	parameter CH = 8,
	parameter PAIRS = 4
)
(
	input wire ref_clk, // clock
	input wire rst, // reset
	input wire reg_wr, // write strobe
	input wire reg_rd, // read strobe
	input wire reg_ack, // access done
	input wire align_fifo_bypass, // bypass mode
	input wire [CH-1:0] recovered_clk_tick, // ticks
	input wire [CH-1:0] work_serial_input, // work bits
	input wire [CH-1:0] protect_serial_input, // protect bits
	input wire [CH-1:0] cdr_serial_in, // recovery bits
	input wire [CH-1:0] input_select_protect, // select in force
	input wire [CH-1:0] work_status, // work status
	input wire [CH-1:0] protect_status, // protect status
	input wire [PAIRS*8-1:0] parallel_out, // pair bytes
	input wire [PAIRS-1:0] parallel_out_valid, // pair valid
	input wire [PAIRS-1:0] parallel_out_ready, // pair ready
	input wire [CH-1:0] parallel_oe, // bus enable
	input wire [CH-1:0] overhead_oe, // overhead enable
	input wire [CH-1:0] macro_powerdown // powerdown
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_pd; macro_powerdown == ~parallel_oe; endproperty
	a_pd: assert property (p_pd) else $error("powerdown differs from enable");
	property p_oe; overhead_oe == parallel_oe; endproperty
	a_oe: assert property (p_oe) else $error("output enables differ");
	property p_rst; $fell(rst) |-> macro_powerdown == {CH{1'b1}}; endproperty
	a_rst: assert property (p_rst) else $error("channel up after reset");
	property p_cdr; cdr_serial_in == ($past(parallel_oe) & ((input_select_protect & $past(protect_serial_input))
		| (~input_select_protect & $past(work_serial_input)))); endproperty
	a_cdr: assert property (p_cdr) else $error("wrong input fed to recovery");
	property p_stat; ((work_status & input_select_protect) | (protect_status & ~input_select_protect))
		== {CH{1'b0}}; endproperty
	a_stat: assert property (p_stat) else $error("status on unselected input");
	property p_hold; parallel_out_valid[0] && !parallel_out_ready[0] |=> parallel_out_valid[0]
		&& $stable(parallel_out[7:0]); endproperty
	a_hold: assert property (p_hold) else $error("pair byte dropped while stalled");
	property p_byp; align_fifo_bypass && !recovered_clk_tick[0] && !parallel_out_valid[0]
		|=> !parallel_out_valid[0]; endproperty
	a_byp: assert property (p_byp) else $error("byte taken without recovered tick");
	property p_ack; reg_wr || reg_rd |=> reg_ack; endproperty
	a_ack: assert property (p_ack) else $error("register access not acknowledged");
endmodule
bind backplane_protection_switch bps_checker #(.CH(CH), .PAIRS(PAIRS)) i_chk (.ref_clk(ref_clk), .rst(rst),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_ack(reg_ack), .align_fifo_bypass(align_fifo_bypass),
	.recovered_clk_tick(recovered_clk_tick), .work_serial_input(work_serial_input),
	.protect_serial_input(protect_serial_input), .cdr_serial_in(cdr_serial_in),
	.input_select_protect(input_select_protect), .work_status(work_status), .protect_status(protect_status),
	.parallel_out(parallel_out), .parallel_out_valid(parallel_out_valid), .parallel_out_ready(parallel_out_ready),
	.parallel_oe(parallel_oe), .overhead_oe(overhead_oe), .macro_powerdown(macro_powerdown));

/* File: test/fabric_model.sv */
// fabric-side model: drives the select pins and takes the pair bytes
// assumes the switch samples pins and handshakes on the rising edge
`timescale 1ns/1ps
module fabric_model
(
	input wire ref_clk, // clock
	input wire rst, // reset
	input wire [3:0] want_pair, // pair selects asked for
	input wire [7:0] want_input, // input selects asked for
	input wire stall, // hold off pair bytes
	output reg [3:0] pair_sel, // pair select pins
	output reg [7:0] input_sel, // input select pins
	input wire [31:0] pair_data, // pair bytes
	input wire [3:0] pair_valid, // pair byte present
	output wire [3:0] pair_ready, // pair byte taken
	output reg [31:0] got, // last byte per pair
	output reg [15:0] got_cnt // pair0 bytes taken
);
	integer p;
	assign pair_ready = {4{~stall}};
	// pins move just after the edge; bytes captured on handshake
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pair_sel <= 4'hf;
			input_sel <= 8'h00;
			got <= 32'h0;
			got_cnt <= 16'h0;
		end
		else
		begin
			pair_sel <= want_pair;
			input_sel <= want_input;
			for (p = 0; p < 4; p = p + 1)
				if (pair_valid[p] && !stall)
					got[8*p +: 8] <= pair_data[8*p +: 8];
			if (pair_valid[0] && !stall)
				got_cnt <= got_cnt + 16'h1;
		end
	end
endmodule
